/* ume_defines.vh */
/*
 * Constants for the endpoint mode engine: register offsets, field
 * positions, mode codes, token kinds, action and reply codes.
 * Assumes inclusion by the Verilog and SystemVerilog files of this block only.
 */
// Behaviour
// (R1) each endpoint mode code in bits 3:0
// (R2) mode 0000 answers no token at all
// (R3) reset to disabled; engine never leaves it
// (R4) 0001 accepts SETUP, NAKs IN and OUT
// (R5) valid SETUP is ACKed, mode becomes 0001
// (R6) control modes 0010 0011 0100 0110 1010
// (R7) reserved 0101 and 0111 behaviours
// (R8) 1000 NAKs OUT; 1001 ACKs, then 1000
// (R9) 1011 ACKs OUT then becomes 0001
// (R10) 1100 NAKs IN; 1101 sends, then 1100
// (R11) 1110/1111 status-check OUT; 1111 then 1110
// (R12) 1010 and 1110 unchanged after ACK
// (R13) endpoint one bit 7 turns ACK into STALL; code applies it only to OUT in 1001 and IN in 1101
// (R14) status OUT ACKed if empty, toggle one
// (R15) IN sends count bytes or empty packet
// (R16) only valid transactions answered, wrong direction ignored
// (R17) interrupt on completion or CRC-corrupted receive
// (R18) data valid if checks pass, count <= 10
// (R19) IN/OUT flags at end, SETUP at data start
// (R20) endpoint zero ACK locks mode/count until read
// (R21) firmware keeps SETUP modes off endpoint one
// (R22) interrupt on final ACK; unACKed IN none
// (R23) engine mode change precedes next token
`ifndef UME_DEFINES_VH
`define UME_DEFINES_VH

// register offsets
`define UME_ADDR_COUNT0 8'h11
`define UME_ADDR_MODE0 8'h12
`define UME_ADDR_COUNT1 8'h13
`define UME_ADDR_MODE1 8'h14

// mode register fields
`define UME_MODE_MSB 3
`define UME_STALL_BIT 7
`define UME_PID_SETUP_BIT 7
`define UME_PID_IN_BIT 6
`define UME_PID_OUT_BIT 5

// count register fields
`define UME_CNT_MSB 3
`define UME_CNT_VALID_BIT 6
`define UME_CNT_TOGGLE_BIT 7

// reset values
`define UME_MODE_RESET 4'h0
`define UME_CNT_RESET 4'h0

// packet limits: eight data bytes plus two CRC bytes
`define UME_MAX_RX_COUNT 4'hA
`define UME_EMPTY_RX_COUNT 4'h2

// mode codes
`define UME_M_DISABLE 4'h0
`define UME_M_NAK_INOUT 4'h1
`define UME_M_STATUS_OUT 4'h2
`define UME_M_STALL_INOUT 4'h3
`define UME_M_IGNORE_INOUT 4'h4
`define UME_M_RSV_OUT 4'h5
`define UME_M_STATUS_IN 4'h6
`define UME_M_RSV_IN 4'h7
`define UME_M_NAK_OUT 4'h8
`define UME_M_ACK_OUT 4'h9
`define UME_M_NAKOUT_STIN 4'hA
`define UME_M_ACKOUT_NAKIN 4'hB
`define UME_M_NAK_IN 4'hC
`define UME_M_ACK_IN 4'hD
`define UME_M_NAKIN_STOUT 4'hE
`define UME_M_ACKIN_STOUT 4'hF

// token kinds
`define UME_TOK_SETUP 2'h1
`define UME_TOK_IN 2'h2
`define UME_TOK_OUT 2'h3

// actions per token
`define UME_A_IGNORE 3'h0
`define UME_A_NAK 3'h1
`define UME_A_STALL 3'h2
`define UME_A_ACK 3'h3
`define UME_A_TXCNT 3'h4
`define UME_A_TX0 3'h5
`define UME_A_CHECK 3'h6

// reply codes towards the packet codec
`define UME_R_NAK 3'h1
`define UME_R_STALL 3'h2
`define UME_R_ACK 3'h3
`define UME_R_DATA 3'h4

`endif

/* ume_mode_decode.v */
/*
 * Mode decoder: turns one endpoint's mode code and stall bit into the
 * action per token kind and the mode the engine writes after an ACK.
 * Assumes a purely combinational use by the engine.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ume_defines.vh"

module ume_mode_decode (
	// mode
	input wire [3:0] mode,
	input wire stall,
	// actions
	output reg setupAccept,
	output reg [2:0] inAction,
	output reg [2:0] outAction,
	output reg [3:0] modeAfterAck
);

	always @* begin
		setupAccept = 1'b1;
		inAction = `UME_A_IGNORE;
		outAction = `UME_A_IGNORE;
		modeAfterAck = mode; // R12
		case (mode)
		`UME_M_DISABLE: begin
			setupAccept = 1'b0; // R2 R3
		end
		`UME_M_NAK_INOUT: begin
			inAction = `UME_A_NAK; // R4
			outAction = `UME_A_NAK;
		end
		`UME_M_STATUS_OUT: begin
			inAction = `UME_A_STALL; // R6
			outAction = `UME_A_CHECK;
		end
		`UME_M_STALL_INOUT: begin
			inAction = `UME_A_STALL; // R6
			outAction = `UME_A_STALL;
		end
		`UME_M_IGNORE_INOUT: begin
			setupAccept = 1'b1; // R6
		end
		`UME_M_RSV_OUT: begin
			setupAccept = 1'b0; // R7
			outAction = `UME_A_ACK;
		end
		`UME_M_STATUS_IN: begin
			inAction = `UME_A_TX0; // R6
			outAction = `UME_A_STALL;
		end
		`UME_M_RSV_IN: begin
			setupAccept = 1'b0; // R7
			inAction = `UME_A_TXCNT;
		end
		`UME_M_NAK_OUT: begin
			setupAccept = 1'b0; // R8
			outAction = `UME_A_NAK;
		end
		`UME_M_ACK_OUT: begin
			setupAccept = 1'b0; // R8
			outAction = stall ? `UME_A_STALL : `UME_A_ACK; // R13
			modeAfterAck = `UME_M_NAK_OUT;
		end
		`UME_M_NAKOUT_STIN: begin
			inAction = `UME_A_TX0; // R6
			outAction = `UME_A_NAK;
		end
		`UME_M_ACKOUT_NAKIN: begin
			inAction = `UME_A_NAK; // R9
			outAction = `UME_A_ACK;
			modeAfterAck = `UME_M_NAK_INOUT;
		end
		`UME_M_NAK_IN: begin
			setupAccept = 1'b0; // R10
			inAction = `UME_A_NAK;
		end
		`UME_M_ACK_IN: begin
			setupAccept = 1'b0; // R10
			inAction = stall ? `UME_A_STALL : `UME_A_TXCNT; // R13
			modeAfterAck = `UME_M_NAK_IN;
		end
		`UME_M_NAKIN_STOUT: begin
			inAction = `UME_A_NAK; // R11
			outAction = `UME_A_CHECK;
		end
		`UME_M_ACKIN_STOUT: begin
			inAction = `UME_A_TXCNT; // R11
			outAction = `UME_A_CHECK;
			modeAfterAck = `UME_M_NAKIN_STOUT;
		end
		default: begin
			setupAccept = 1'b0;
		end
		endcase
	end

endmodule // ume_mode_decode
`default_nettype wire

/* ume_mode_engine.v */
/*
 * Endpoint mode engine for a two-endpoint low-speed serial interface
 * engine: mode/count registers, token handling, automatic mode change,
 * PID status flags, endpoint event pulses and the endpoint-zero lock.
 * Assumes a packet codec on the same clock that delivers decoded tokens,
 * data packet summaries and host handshakes, and sends the replies.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ume_defines.vh"

module ume_mode_engine (
	// clock and reset
	input wire clock,
	input wire reset,
	// register port
	input wire [7:0] regAddr,
	input wire [7:0] regWrData,
	input wire regWrite,
	input wire regRead,
	output reg [7:0] regRdData,
	// token from codec
	input wire tokenStrobe,
	input wire [1:0] tokenKind,
	input wire tokenEndpoint,
	input wire tokenAddrMatch,
	// data packet from codec
	input wire dataStart,
	input wire dataDone,
	input wire [3:0] dataCount,
	input wire dataToggle,
	input wire dataCrcOk,
	input wire dataChecksOk,
	// host handshake after an IN data packet
	input wire hostAck,
	input wire hostTimeout,
	// reply to codec
	output reg replyStrobe,
	output reg [2:0] replyCode,
	output reg [3:0] replyCount,
	// endpoint events
	output reg [1:0] endpointEvent,
	// endpoint-zero lock state
	output reg endpointZeroLocked
);

	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_WAIT_DATA = 2'h1;
	localparam [1:0] ST_WAIT_HANDSHAKE = 2'h2;
	reg [1:0] state;
	reg [3:0] mode0;
	reg [3:0] mode1;
	reg stallBit1;
	reg pidSetup;
	reg pidIn;
	reg pidOut;
	reg [3:0] count0;
	reg [3:0] count1;
	reg rxValid0;
	reg rxValid1;
	reg rxToggle0;
	reg rxToggle1;
	reg curEndpoint;
	reg [1:0] curKind;
	reg [2:0] curAction;
	// decoders, one per endpoint
	wire setupAccept0;
	wire setupAccept1;
	wire [2:0] inAction0;
	wire [2:0] inAction1;
	wire [2:0] outAction0;
	wire [2:0] outAction1;
	wire [3:0] afterAck0;
	wire [3:0] afterAck1;

	ume_mode_decode decode0 (
		.mode(mode0),
		.stall(1'b0),
		.setupAccept(setupAccept0),
		.inAction(inAction0),
		.outAction(outAction0),
		.modeAfterAck(afterAck0)
	);
	ume_mode_decode decode1 (
		.mode(mode1),
		.stall(stallBit1), // R13
		.setupAccept(setupAccept1),
		.inAction(inAction1),
		.outAction(outAction1),
		.modeAfterAck(afterAck1)
	);
	wire tokSetupAccept = tokenEndpoint ? setupAccept1 : setupAccept0;
	wire [2:0] tokIn = tokenEndpoint ? inAction1 : inAction0;
	wire [2:0] tokOut = tokenEndpoint ? outAction1 : outAction0;
	wire [3:0] curAfterAck = curEndpoint ? afterAck1 : afterAck0;
	wire tokIsSetup = tokenKind == `UME_TOK_SETUP;
	wire tokIsIn = tokenKind == `UME_TOK_IN;
	wire tokIsOut = tokenKind == `UME_TOK_OUT;
	wire curIsSetup = curKind == `UME_TOK_SETUP;
	// received data packet checks
	wire rxValid = dataCrcOk && dataChecksOk && dataCount <= `UME_MAX_RX_COUNT; // R18
	wire statusOk = dataCount == `UME_EMPTY_RX_COUNT && dataToggle; // R14
	// engine decisions, evaluated combinationally each cycle
	reg engReply;
	reg [2:0] engCode;
	reg [3:0] engReplyCount;
	reg engModeWrite;
	reg [3:0] engMode;
	reg engEvent;
	reg engAckDone;
	reg engRxStore;
	reg engSetPidIn;
	reg engSetPidOut;
	reg engSetPidSetup;
	reg [1:0] next_state;
	always @* begin
		engReply = 1'b0;
		engCode = `UME_R_NAK;
		engReplyCount = 4'h0;
		engModeWrite = 1'b0;
		engMode = curAfterAck;
		engEvent = 1'b0;
		engAckDone = 1'b0;
		engRxStore = 1'b0;
		engSetPidIn = 1'b0;
		engSetPidOut = 1'b0;
		engSetPidSetup = 1'b0;
		next_state = state;
		case (state)
		ST_IDLE: begin
			if (tokenStrobe && tokenAddrMatch) begin
				if (tokIsSetup && tokSetupAccept) begin
					next_state = ST_WAIT_DATA;
				end else if (tokIsOut && tokOut != `UME_A_IGNORE) begin
					next_state = ST_WAIT_DATA;
				end else if (tokIsIn) begin
					case (tokIn)
					`UME_A_NAK, `UME_A_STALL: begin
						engReply = 1'b1;
						engCode = tokIn == `UME_A_NAK ? `UME_R_NAK : `UME_R_STALL;
						engEvent = 1'b1; // R17
						engSetPidIn = 1'b1; // R19
					end
					`UME_A_TXCNT: begin
						engReply = 1'b1; // R15
						engCode = `UME_R_DATA;
						engReplyCount = tokenEndpoint ? count1 : count0;
						next_state = ST_WAIT_HANDSHAKE;
					end
					`UME_A_TX0: begin
						engReply = 1'b1; // R15
						engCode = `UME_R_DATA;
						next_state = ST_WAIT_HANDSHAKE;
					end
					default: begin
						engReply = 1'b0; // R16
					end
					endcase
				end
			end
		end
		ST_WAIT_DATA: begin
			if (dataStart && curIsSetup) begin
				engSetPidSetup = 1'b1; // R19
			end
			if (dataDone) begin
				next_state = ST_IDLE;
				if (!rxValid) begin
					// corrupted buffer still raises an event
					engEvent = !dataCrcOk; // R17
					engRxStore = curIsSetup || curAction == `UME_A_ACK;
				end else if (curIsSetup) begin
					engReply = 1'b1; // R5
					engCode = `UME_R_ACK;
					engModeWrite = 1'b1;
					engMode = `UME_M_NAK_INOUT;
					engEvent = 1'b1;
					engAckDone = 1'b1;
					engRxStore = 1'b1;
				end else begin
					engReply = 1'b1;
					engEvent = 1'b1; // R17 R22
					engSetPidOut = 1'b1; // R19
					case (curAction)
					`UME_A_ACK: begin
						engCode = `UME_R_ACK; // R8 R9
						engModeWrite = 1'b1; // R23
						engAckDone = 1'b1;
						engRxStore = 1'b1;
					end
					`UME_A_CHECK: begin
						if (statusOk) begin
							engCode = `UME_R_ACK; // R14
							engAckDone = 1'b1;
						end else begin
							engCode = `UME_R_STALL;
							engModeWrite = 1'b1;
							engMode = `UME_M_STALL_INOUT;
						end
					end
					`UME_A_STALL: begin
						engCode = `UME_R_STALL;
						if (curEndpoint == 1'b0 && mode0 == `UME_M_STATUS_IN) begin
							engModeWrite = 1'b1;
							engMode = `UME_M_STALL_INOUT;
						end
					end
					default: begin
						engCode = `UME_R_NAK;
					end
					endcase
				end
			end
		end
		ST_WAIT_HANDSHAKE: begin
			if (hostAck) begin
				next_state = ST_IDLE;
				engEvent = 1'b1; // R22
				engSetPidIn = 1'b1; // R19
				engAckDone = 1'b1;
				engModeWrite = 1'b1; // R10 R11 R12
			end else if (hostTimeout) begin
				next_state = ST_IDLE; // R22
			end
		end
		default: begin
			next_state = ST_IDLE;
		end
		endcase
	end
	// software access decode
	wire wrMode0 = regWrite && regAddr == `UME_ADDR_MODE0 && !endpointZeroLocked; // R20
	wire wrCount0 = regWrite && regAddr == `UME_ADDR_COUNT0 && !endpointZeroLocked; // R20
	wire wrMode1 = regWrite && regAddr == `UME_ADDR_MODE1;
	wire wrCount1 = regWrite && regAddr == `UME_ADDR_COUNT1;
	wire rdUnlock = regRead && (regAddr == `UME_ADDR_MODE0 || regAddr == `UME_ADDR_COUNT0);
	wire ackOnZero = engAckDone && curEndpoint == 1'b0;
	// transaction tracking
	always @(posedge clock) begin
		if (reset) begin
			state <= ST_IDLE;
			curEndpoint <= 1'b0;
			curKind <= 2'h0;
			curAction <= `UME_A_IGNORE;
		end else begin
			state <= next_state;
			if (state == ST_IDLE && tokenStrobe && tokenAddrMatch) begin
				curEndpoint <= tokenEndpoint;
				curKind <= tokenKind;
				curAction <= tokIsOut ? tokOut : tokIn; // R16
			end
		end
	end
	// mode registers: engine change wins over software write
	always @(posedge clock) begin
		if (reset) begin
			mode0 <= `UME_MODE_RESET; // R3
			mode1 <= `UME_MODE_RESET;
			stallBit1 <= 1'b0;
		end else begin
			if (engModeWrite && curEndpoint == 1'b0) begin
				mode0 <= engMode; // R23
			end else if (wrMode0) begin
				mode0 <= regWrData[`UME_MODE_MSB:0]; // R1
			end
			if (engModeWrite && curEndpoint == 1'b1) begin
				mode1 <= engMode; // R23
			end else if (wrMode1) begin
				mode1 <= regWrData[`UME_MODE_MSB:0]; // R1
			end
			if (wrMode1) begin
				stallBit1 <= regWrData[`UME_STALL_BIT]; // R13
			end
		end
	end
	// endpoint-zero PID flags: set wins over the clearing write
	always @(posedge clock) begin
		if (reset) begin
			pidSetup <= 1'b0;
			pidIn <= 1'b0;
			pidOut <= 1'b0;
		end else begin
			if (engSetPidSetup && curEndpoint == 1'b0) begin
				pidSetup <= 1'b1; // R19
			end else if (wrMode0) begin
				pidSetup <= 1'b0;
			end
			if (engSetPidIn && (state == ST_IDLE ? tokenEndpoint : curEndpoint) == 1'b0) begin
				pidIn <= 1'b1; // R19
			end else if (wrMode0) begin
				pidIn <= 1'b0;
			end
			if (engSetPidOut && curEndpoint == 1'b0) begin
				pidOut <= 1'b1; // R19
			end else if (wrMode0) begin
				pidOut <= 1'b0;
			end
		end
	end
	// count registers: received summary or software count
	always @(posedge clock) begin
		if (reset) begin
			count0 <= `UME_CNT_RESET;
			count1 <= `UME_CNT_RESET;
			rxValid0 <= 1'b0;
			rxValid1 <= 1'b0;
			rxToggle0 <= 1'b0;
			rxToggle1 <= 1'b0;
		end else begin
			if (engRxStore && curEndpoint == 1'b0) begin
				count0 <= dataCount;
				rxValid0 <= rxValid; // R18
				rxToggle0 <= dataToggle;
			end else if (wrCount0) begin
				count0 <= regWrData[`UME_CNT_MSB:0];
			end
			if (engRxStore && curEndpoint == 1'b1) begin
				count1 <= dataCount;
				rxValid1 <= rxValid; // R18
				rxToggle1 <= dataToggle;
			end else if (wrCount1) begin
				count1 <= regWrData[`UME_CNT_MSB:0];
			end
		end
	end
	// endpoint-zero write lock, also after a host-ACKed IN
	always @(posedge clock) begin
		if (reset) begin
			endpointZeroLocked <= 1'b0;
		end else if (ackOnZero) begin
			endpointZeroLocked <= 1'b1; // R20
		end else if (rdUnlock && state == ST_IDLE) begin
			endpointZeroLocked <= 1'b0; // R20
		end
	end
	// replies and events
	always @(posedge clock) begin
		if (reset) begin
			replyStrobe <= 1'b0;
			replyCode <= `UME_R_NAK;
			replyCount <= 4'h0;
			endpointEvent <= 2'h0;
		end else begin
			replyStrobe <= engReply; // R16
			if (engReply) begin
				replyCode <= engCode;
				replyCount <= engReplyCount; // R15
			end
			endpointEvent[0] <= engEvent && (state == ST_IDLE ? !tokenEndpoint : !curEndpoint);
			endpointEvent[1] <= engEvent && (state == ST_IDLE ? tokenEndpoint : curEndpoint);
		end
	end
	// register read data, one cycle after the strobe
	always @(posedge clock) begin
		if (reset) begin
			regRdData <= 8'h00;
		end else if (regRead) begin
			case (regAddr)
			`UME_ADDR_MODE0: regRdData <= {pidSetup, pidIn, pidOut, 1'b0, mode0};
			`UME_ADDR_MODE1: regRdData <= {stallBit1, 3'h0, mode1};
			`UME_ADDR_COUNT0: regRdData <= {rxToggle0, rxValid0, 2'h0, count0};
			`UME_ADDR_COUNT1: regRdData <= {rxToggle1, rxValid1, 2'h0, count1};
			default: regRdData <= 8'h00;
			endcase
		end else begin
			regRdData <= 8'h00;
		end
	end

endmodule // ume_mode_engine
`default_nettype wire

/* ume_mode_engine_sva.sv */
/* Port checker for the endpoint mode engine.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
`include "ume_defines.vh"
module ume_mode_engine_sva (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic regRead,
	input wire logic [7:0] regRdData,
	// codec side
	input wire logic tokenStrobe,
	input wire logic [1:0] tokenKind,
	input wire logic dataDone,
	input wire logic [3:0] dataCount,
	input wire logic dataCrcOk,
	input wire logic hostAck,
	input wire logic hostTimeout,
	input wire logic replyStrobe,
	input wire logic [2:0] replyCode,
	input wire logic [1:0] endpointEvent,
	input wire logic endpointZeroLocked
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);
	rd_idle_zero_a: assert property (!regRead |=> regRdData == 8'h00)
		else $error("read data not zero");
	reply_has_cause_a: assert property (replyStrobe |-> $past(tokenStrobe) || $past(dataDone))
		else $error("reply without cause");
	data_after_in_a: assert property (replyStrobe && replyCode == `UME_R_DATA
		|-> $past(tokenStrobe && tokenKind == `UME_TOK_IN)) else $error("data reply not after IN");
	bad_crc_quiet_a: assert property (dataDone && !dataCrcOk |=> !replyStrobe)
		else $error("reply to bad packet");
	oversize_quiet_a: assert property (dataDone && dataCount > `UME_MAX_RX_COUNT |=> !replyStrobe)
		else $error("reply to oversize packet");
	ack_event_a: assert property (replyStrobe && replyCode == `UME_R_ACK |-> endpointEvent != 2'h0)
		else $error("ACK without event");
	host_ack_event_a: assert property (hostAck |=> endpointEvent != 2'h0)
		else $error("host ACK without event");
	lock_on_ack_a: assert property ($rose(endpointZeroLocked) |->
		(replyStrobe && replyCode == `UME_R_ACK) || $past(hostAck)) else $error("lock without ACK");
	unlock_by_read_a: assert property ($fell(endpointZeroLocked) |-> $past(regRead) &&
		($past(regAddr) == `UME_ADDR_MODE0 || $past(regAddr) == `UME_ADDR_COUNT0)) else $error("unlock without read");
	setup_lock_c: cover property ($rose(endpointZeroLocked));
	data_reply_c: cover property (replyStrobe && replyCode == `UME_R_DATA);
	timeout_c: cover property (hostTimeout);
endmodule // ume_mode_engine_sva
bind ume_mode_engine ume_mode_engine_sva ume_mode_engine_sva_i (.clock, .reset, .regAddr, .regRead,
	.regRdData, .tokenStrobe, .tokenKind, .dataDone, .dataCount, .dataCrcOk, .hostAck, .hostTimeout,
	.replyStrobe, .replyCode, .endpointEvent, .endpointZeroLocked);
`default_nettype wire

/* ume_host_model.sv */
/* Codec-side partner: host tokens, data packet summaries, host handshakes.
   Assumes the bench calls its tasks right after a rising clock edge. */
`timescale 1ns/1ps
`default_nettype none
`include "ume_defines.vh"
module ume_host_model (
	// clock
	input wire logic clock,
	// token
	output logic tokenStrobe,
	output logic [1:0] tokenKind,
	output logic tokenEndpoint,
	output logic tokenAddrMatch,
	// data packet
	output logic dataStart,
	output logic dataDone,
	output logic [3:0] dataCount,
	output logic dataToggle,
	output logic dataCrcOk,
	output logic dataChecksOk,
	// handshake
	output logic hostAck,
	output logic hostTimeout
);
	initial begin
		{tokenStrobe, tokenKind, tokenEndpoint, tokenAddrMatch, dataStart, dataDone} = '0;
		{dataCount, dataToggle, dataCrcOk, dataChecksOk, hostAck, hostTimeout} = '0;
	end
	// token, then a data packet for SETUP and OUT
	task automatic send(input logic [1:0] k, input logic ep, input logic hit,
		input logic [3:0] n, input logic tg, input logic ok, input int gap);
		tokenKind <= k;
		tokenEndpoint <= ep;
		tokenAddrMatch <= hit;
		tokenStrobe <= 1'b1;
		@(posedge clock);
		tokenStrobe <= 1'b0;
		tokenKind <= ~k;
		tokenEndpoint <= ~ep;
		if (k != `UME_TOK_IN) begin
			repeat (gap + 1) @(posedge clock);
			dataStart <= 1'b1;
			@(posedge clock);
			dataStart <= 1'b0;
			repeat (gap + 2) @(posedge clock);
			dataCount <= n;
			dataToggle <= tg;
			dataCrcOk <= ok;
			dataChecksOk <= 1'b1;
			dataDone <= 1'b1;
			@(posedge clock);
			dataDone <= 1'b0;
			dataCount <= ~n;
			dataToggle <= ~tg;
			dataChecksOk <= 1'b0;
		end
	endtask
	// host answer to an IN data packet, ACK or timeout
	task automatic shake(input logic ack, input int gap);
		repeat (gap + 1) @(posedge clock);
		hostAck <= ack;
		hostTimeout <= !ack;
		@(posedge clock);
		hostAck <= 1'b0;
		hostTimeout <= 1'b0;
	endtask
endmodule // ume_host_model
`default_nettype wire

/* ume_mode_engine_tb.sv */
/* Self-checking bench for the mode engine with random transactions.
   Assumes the codec-side partner model and the bound port checker. */
`timescale 1ns/1ps
`default_nettype none
`include "ume_defines.vh"
module ume_mode_engine_tb;
	localparam logic [63:0] inAct = 64'h4141150045002210;
	localparam logic [63:0] outAct = 64'h6600313102302610;
	localparam logic [15:0] setupOk = 16'hCC5E;
	logic [3:0] safeModes [0:6] = '{4'h0, 4'h5, 4'h7, 4'h8, 4'h9, 4'hC, 4'hD};
	logic clock, reset, regWrite, regRead, tokenStrobe, tokenEndpoint, tokenAddrMatch;
	logic dataStart, dataDone, dataToggle, dataCrcOk, dataChecksOk, hostAck, hostTimeout;
	logic replyStrobe, endpointZeroLocked, ep, s, tg, ok, hit, ack, eEv, keepMode;
	logic [7:0] regAddr, regWrData, regRdData, d;
	logic [3:0] dataCount, replyCount, m, n, cnt, eMode, eCnt, gotCnt;
	logic [2:0] replyCode, eRep, gotRep;
	logic [1:0] tokenKind, endpointEvent, k, gotEv;
	int gap, error_cnt = 0, n_checks = 0;
	ume_mode_engine ume_mode_engine_i (.clock, .reset, .regAddr, .regWrData, .regWrite,
		.regRead, .regRdData, .tokenStrobe, .tokenKind, .tokenEndpoint, .tokenAddrMatch,
		.dataStart, .dataDone, .dataCount, .dataToggle, .dataCrcOk, .dataChecksOk, .hostAck,
		.hostTimeout, .replyStrobe, .replyCode, .replyCount, .endpointEvent, .endpointZeroLocked);
	ume_host_model ume_host_model_i (.clock, .tokenStrobe, .tokenKind, .tokenEndpoint,
		.tokenAddrMatch, .dataStart, .dataDone, .dataCount, .dataToggle, .dataCrcOk,
		.dataChecksOk, .hostAck, .hostTimeout);
	always #5 clock = ~clock;
	always @(posedge clock) begin
		if (replyStrobe === 1'b1) begin
			gotRep <= replyCode;
			gotCnt <= replyCount;
		end
		if (endpointEvent !== 2'h0) gotEv <= endpointEvent;
	end
	task automatic summarize();
		if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		regAddr <= a;
		regWrData <= v;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		@(posedge clock);
		v = regRdData;
	endtask
	// expected reply, event and mode, then one transaction and the compares
	task automatic run();
		logic [2:0] a;
		eRep = 3'h0;
		eCnt = 4'h0;
		eMode = m;
		keepMode = 1'b1;
		a = k == `UME_TOK_IN ? inAct[{m, 2'b00} +: 3] : outAct[{m, 2'b00} +: 3];
		if (k == `UME_TOK_SETUP) a = setupOk[m] ? `UME_A_ACK : `UME_A_IGNORE;
		if (a == `UME_A_CHECK) a = n == `UME_EMPTY_RX_COUNT && tg ? `UME_A_ACK : 3'h7;
		if (s && (m == `UME_M_ACK_OUT || m == `UME_M_ACK_IN) &&
			a != `UME_A_IGNORE) a = `UME_A_STALL;
		if (!hit) a = `UME_A_IGNORE;
		eEv = a != `UME_A_IGNORE;
		if (a == `UME_A_NAK) eRep = `UME_R_NAK;
		if (a == `UME_A_STALL || a == 3'h7) eRep = `UME_R_STALL;
		if (a == 3'h7 || (a == `UME_A_STALL && m == `UME_M_STATUS_IN)) eMode = `UME_M_STALL_INOUT;
		if (a >= `UME_A_TXCNT && a < 3'h6) eRep = `UME_R_DATA;
		if (a == `UME_A_TXCNT) eCnt = cnt;
		if (a == `UME_A_ACK && ok && n <= `UME_MAX_RX_COUNT) begin
			eRep = `UME_R_ACK;
			eMode = k == `UME_TOK_SETUP ? `UME_M_NAK_INOUT : m == `UME_M_ACK_OUT ? `UME_M_NAK_OUT :
				m == `UME_M_ACKOUT_NAKIN ? `UME_M_NAK_INOUT : m;
			keepMode = k == `UME_TOK_SETUP || (m != `UME_M_RSV_OUT && m != `UME_M_STATUS_OUT);
		end
		if (a == `UME_A_ACK && eRep == 3'h0) eEv = !ok;
		if (eRep == `UME_R_DATA) begin
			eEv = ack;
			if (ack && m == `UME_M_ACK_IN) eMode = `UME_M_NAK_IN;
			if (ack && m == `UME_M_ACKIN_STOUT) eMode = `UME_M_NAKIN_STOUT;
			keepMode = !(ack && m == `UME_M_RSV_IN);
		end
		gotRep = 3'h0;
		gotEv = 2'h0;
		ume_host_model_i.send(k, ep, hit, n, tg, ok, gap);
		if (eRep == `UME_R_DATA) ume_host_model_i.shake(ack, gap);
		repeat (4) @(posedge clock);
		check(8'(gotRep), 8'(eRep));
		if (eRep == `UME_R_DATA) check(8'(gotCnt), 8'(eCnt));
		check(8'(gotEv), eEv ? (ep ? 8'h02 : 8'h01) : 8'h00);
		check(8'(endpointZeroLocked),
			8'(!ep && (eRep == `UME_R_ACK || (eRep == `UME_R_DATA && ack))));
		rd(ep ? `UME_ADDR_MODE1 : `UME_ADDR_MODE0, d);
		if (keepMode) check(8'({d[7] & ep, d[3:0]}), 8'({s, eMode}));
		if (!ep && a == `UME_A_ACK && k == `UME_TOK_SETUP) check(8'(d[7]), 8'h01);
		if (!ep && k != `UME_TOK_SETUP) check(8'(d[7:5]),
			8'({1'b0, eEv && k == `UME_TOK_IN, eEv && k == `UME_TOK_OUT}));
	endtask
	initial begin
		repeat (30000) @(posedge clock);
		error_cnt++;
		summarize();
	end
	initial begin
		clock = 1'b0;
		reset = 1'b1;
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
		void'($urandom(75288));
		repeat (6) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		for (int i = 0; i < 5; i++) begin
			rd(i == 4 ? 8'h20 : 8'h11 + 8'(i), d);
			check(d, 8'h00);
		end
		// locked mode write is dropped until read
		wr(`UME_ADDR_MODE0, 8'h01);
		ume_host_model_i.send(`UME_TOK_SETUP, 1'b0, 1'b1, 4'hA, 1'b0, 1'b1, 0);
		repeat (4) @(posedge clock);
		wr(`UME_ADDR_MODE0, 8'h0F);
		check(8'(endpointZeroLocked), 8'h01);
		rd(`UME_ADDR_MODE0, d);
		check(8'(d[3:0]), 8'h01);
		wr(`UME_ADDR_MODE0, 8'h04);
		rd(`UME_ADDR_MODE0, d);
		check(8'(d[3:0]), 8'h04);
		repeat (150) begin
			ep = 1'($urandom_range(1, 0));
			m = ep ? safeModes[$urandom_range(6, 0)] : 4'($urandom_range(15, 0));
			s = ep & 1'($urandom_range(1, 0));
			k = 2'($urandom_range(3, 1));
			hit = $urandom_range(7, 0) != 0;
			n = 4'($urandom_range(k == `UME_TOK_SETUP ? 12 : 10, 0));
			if (k == `UME_TOK_OUT && $urandom_range(1, 0) == 1) n = `UME_EMPTY_RX_COUNT;
			tg = 1'($urandom_range(1, 0));
			ok = k != `UME_TOK_SETUP || $urandom_range(3, 0) != 0;
			ack = 1'($urandom_range(1, 0));
			gap = $urandom_range(3, 0);
			cnt = 4'($urandom_range(8, 0));
			wr(ep ? `UME_ADDR_COUNT1 : `UME_ADDR_COUNT0, 8'(cnt));
			wr(ep ? `UME_ADDR_MODE1 : `UME_ADDR_MODE0, {s, 3'h0, m});
			run();
		end
		summarize();
	end
endmodule // ume_mode_engine_tb
`default_nettype wire
